// ===== design/sdac_ctrl.sv
// Overview of operation
// RULE_01 - Two-bit field picks converter reference
// RULE_02 - Gain bit selects converter gain one/two
// RULE_03 - Three-bit code sets amplifier gain power-of-two
// RULE_04 - Link bit ties selected inputs together
// RULE_05 - Bypass bit routes inputs around amplifier
// RULE_06 - Software enables amplifier before use
// RULE_07 - Negative input field selects negative source
// RULE_08 - Positive input field selects positive source
// RULE_09 - Result shown in three read-only bytes
// RULE_10 - Filter reset aborts and holds conversions
// RULE_11 - Control A bit 5 enables decimator
// RULE_12 - Four-bit field selects oversampling ratio
// RULE_13 - Three-bit field selects clock divide factor
// RULE_14 - Latch bit freezes result registers
// RULE_15 - Latched: no interrupt, flag unchanged
// RULE_16 - Software latches before reading bytes
// RULE_17 - End flag set by hardware, software clears
// RULE_18 - Control C bit 4 enables modulator
// RULE_19 - Reserved control C bits keep reset
// RULE_20 - Unimplemented bits ignore writes, read zero
// RULE_21 - Conversion end sets flag and request
// RULE_22 - Software pulses filter reset to start
// RULE_23 - Unlatched results replace data registers
// RULE_24 - All three bytes load together
// RULE_25 - Reserved codes keep previous legal setting
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sdac_defines.svh"

module sdac_ctrl
  import sdac_pkg::*;
#(
  parameter int DATA_W = 24
) (
  input  wire logic               CLK,
  input  wire logic               SRST,
  input  wire logic [7:0]         S_AXI_AWADDR,
  input  wire logic               S_AXI_AWVALID,
  output logic                    S_AXI_AWREADY,
  input  wire logic [31:0]        S_AXI_WDATA,
  input  wire logic [3:0]         S_AXI_WSTRB,
  input  wire logic               S_AXI_WVALID,
  output logic                    S_AXI_WREADY,
  output logic [1:0]              S_AXI_BRESP,
  output logic                    S_AXI_BVALID,
  input  wire logic               S_AXI_BREADY,
  input  wire logic [7:0]         S_AXI_ARADDR,
  input  wire logic               S_AXI_ARVALID,
  output logic                    S_AXI_ARREADY,
  output logic [31:0]             S_AXI_RDATA,
  output logic [1:0]              S_AXI_RRESP,
  output logic                    S_AXI_RVALID,
  input  wire logic               S_AXI_RREADY,
  input  wire logic               MOD_BIT,
  input  wire logic [DATA_W-1:0]  FILTER_DATA,
  input  wire logic               FILTER_DONE,
  output sdac_analog_t            ANALOG_CTRL,
  output logic                    MOD_CLK,
  output logic [15:0]             OSR_VALUE,
  output logic                    ADC_IRQ_REQ
);

  // =====================================================
  // Decode functions
  function automatic logic [7:0] amp_gain_decode(input logic [2:0] code);
    amp_gain_decode = 8'h01 << code;
  endfunction

  function automatic logic [7:0] rd_mux(input logic [7:0] addr,
                                        input logic [7:0] r0, input logic [7:0] r1,
                                        input logic [7:0] r2, input logic [23:0] res,
                                        input logic [7:0] ra, input logic [7:0] rb,
                                        input logic [7:0] rc);
    case (addr)
      `SDAC_ADDR_PGA_GAIN_REF: rd_mux = r0;
      `SDAC_ADDR_PGA_CONN:     rd_mux = r1;
      `SDAC_ADDR_CHAN_SEL:     rd_mux = r2;
      `SDAC_ADDR_RES_LOW:      rd_mux = res[7:0];
      `SDAC_ADDR_RES_MID:      rd_mux = res[15:8];
      `SDAC_ADDR_RES_HIGH:     rd_mux = res[23:16];
      `SDAC_ADDR_CTRL_A:       rd_mux = ra;
      `SDAC_ADDR_CTRL_B:       rd_mux = rb;
      `SDAC_ADDR_CTRL_C:       rd_mux = rc;
      default:                 rd_mux = 8'h00;
    endcase
  endfunction

  function automatic logic addr_ok(input logic [7:0] addr);
    addr_ok = (addr <= `SDAC_ADDR_CTRL_C) && (addr[1:0] == 2'h0);
  endfunction

  // =====================================================
  // Registers
  logic [7:0]  gain_ref_reg;
  logic [7:0]  conn_reg;
  logic [7:0]  chan_reg;
  logic [7:0]  ctrl_a_reg;
  logic [7:0]  ctrl_b_reg;
  logic [7:0]  ctrl_c_reg;
  logic [23:0] result_reg;
  logic [1:0]  mod_sync_reg;
  logic        done_sync1_reg;
  logic        done_sync2_reg;
  logic        done_prev_reg;
  logic [4:0]  div_cnt_reg;
  logic [4:0]  div_max_reg;
  logic [15:0] osr_reg;

  // =====================================================
  // AXI write path
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  aw_addr_reg;
  logic [7:0]  w_data_reg;
  logic        w_strb_reg;
  wire         aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
  wire         w_take  = S_AXI_WVALID && S_AXI_WREADY;
  wire         wr_go   = aw_held_reg && w_held_reg && !S_AXI_BVALID;
  wire         wr_en   = wr_go && w_strb_reg;
  wire [7:0]   wd      = w_data_reg;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 8'h00;
      w_strb_reg    <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= 2'h0;
    end else begin
      S_AXI_AWREADY <= !aw_held_reg && !aw_take && !S_AXI_BVALID;
      S_AXI_WREADY  <= !w_held_reg && !w_take && !S_AXI_BVALID;
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA[7:0];
        w_strb_reg <= S_AXI_WSTRB[0];
      end
      if (wr_go) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= addr_ok(aw_addr_reg) ? 2'h0 : 2'h2;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // =====================================================
  // Write decode with reserved-code filtering
  wire wr_gr = wr_en && (aw_addr_reg == `SDAC_ADDR_PGA_GAIN_REF);
  wire wr_cn = wr_en && (aw_addr_reg == `SDAC_ADDR_PGA_CONN);
  wire wr_ch = wr_en && (aw_addr_reg == `SDAC_ADDR_CHAN_SEL);
  wire wr_a  = wr_en && (aw_addr_reg == `SDAC_ADDR_CTRL_A);
  wire wr_b  = wr_en && (aw_addr_reg == `SDAC_ADDR_CTRL_B);
  wire wr_c  = wr_en && (aw_addr_reg == `SDAC_ADDR_CTRL_C);

  wire [3:0] neg_new  = wd[7:4];
  wire [3:0] pos_new  = wd[3:0];
  wire       neg_ok   = (neg_new >= `SDAC_NEG_MIN) && (neg_new <= `SDAC_NEG_MAX); // RULE_07
  wire       pos_ok   = (pos_new >= `SDAC_POS_MIN) && (pos_new <= `SDAC_POS_MAX); // RULE_08
  wire [3:0] osr_new  = wd[`SDAC_LSB_OSR +: 4];
  wire       osr_ok   = osr_new <= `SDAC_OSR_MAX_CODE;                            // RULE_12
  wire [2:0] div_new  = wd[`SDAC_LSB_CLKDIV +: 3];
  wire       div_ok   = (div_new == `SDAC_DIV30_CODE) || (div_new == `SDAC_DIV12_CODE); // RULE_13
  wire [7:0] chan_nx  = {neg_ok ? neg_new : chan_reg[7:4],
                         pos_ok ? pos_new : chan_reg[3:0]};                         // RULE_25
  wire [7:0] a_wr     = wd & `SDAC_MASK_CTRL_A;
  wire [7:0] ctrl_a_nx = osr_ok ? a_wr
                       : {a_wr[7:5], ctrl_a_reg[4:1], 1'b0};                       // RULE_25
  wire [2:0] div_keep = div_ok ? div_new : ctrl_b_reg[7:5];                        // RULE_25

  // =====================================================
  // Conversion event tracking
  wire filt_rst   = ctrl_a_reg[`SDAC_BIT_FILT_RST];
  wire dec_en     = ctrl_a_reg[`SDAC_BIT_DEC_EN];
  wire mod_en     = ctrl_c_reg[`SDAC_BIT_MOD_EN];
  wire latch_on   = ctrl_b_reg[`SDAC_BIT_LATCH];
  wire conv_end   = done_sync2_reg && !done_prev_reg && dec_en && mod_en && !filt_rst; // RULE_10 RULE_11 RULE_18
  wire eoc_set    = conv_end && !latch_on;                                         // RULE_15 RULE_21
  wire eoc_wr_clr = wr_b && !wd[`SDAC_BIT_EOC];
  wire eoc_next   = eoc_set ? 1'b1
                  : (eoc_wr_clr ? 1'b0 : ctrl_b_reg[`SDAC_BIT_EOC]);               // RULE_17

  always_ff @(posedge CLK) begin
    if (SRST) begin
      gain_ref_reg <= `SDAC_RST_ZERO;
      conn_reg     <= `SDAC_RST_ZERO;
      chan_reg     <= `SDAC_RST_CHAN_SEL;
      ctrl_a_reg   <= `SDAC_RST_ZERO;
      ctrl_b_reg   <= `SDAC_RST_ZERO;
      ctrl_c_reg   <= `SDAC_RST_CTRL_C;
    end else begin
      if (wr_gr) begin
        gain_ref_reg <= wd & `SDAC_MASK_PGA_GAIN_REF;                              // RULE_20
      end
      if (wr_cn) begin
        conn_reg <= wd & `SDAC_MASK_PGA_CONN;                                      // RULE_20
      end
      if (wr_ch) begin
        chan_reg <= chan_nx;
      end
      if (wr_a) begin
        ctrl_a_reg <= ctrl_a_nx;
      end
      if (wr_c) begin
        ctrl_c_reg <= (ctrl_c_reg & ~`SDAC_MASK_CTRL_C_WR)
                    | (wd & `SDAC_MASK_CTRL_C_WR);                                 // RULE_19
      end
      ctrl_b_reg <= {wr_b ? div_keep : ctrl_b_reg[7:5], 2'b00,
                     wr_b ? wd[`SDAC_BIT_LATCH] : ctrl_b_reg[`SDAC_BIT_LATCH],
                     eoc_next, 1'b0};                                              // RULE_17
    end
  end

  // =====================================================
  // Result capture
  always_ff @(posedge CLK) begin
    if (SRST) begin
      result_reg <= 24'h000000;
    end else if (conv_end && !latch_on) begin
      result_reg <= FILTER_DATA[23:0];                                             // RULE_14 RULE_23 RULE_24
    end
  end

  // =====================================================
  // Input synchronisers
  always_ff @(posedge CLK) begin
    if (SRST) begin
      mod_sync_reg   <= 2'b00;
      done_sync1_reg <= 1'b0;
      done_sync2_reg <= 1'b0;
      done_prev_reg  <= 1'b0;
    end else begin
      mod_sync_reg   <= {mod_sync_reg[0], MOD_BIT};
      done_sync1_reg <= FILTER_DONE;
      done_sync2_reg <= done_sync1_reg;
      done_prev_reg  <= done_sync2_reg;
    end
  end

  // =====================================================
  // Converter clock divider and oversampling ratio
  wire [4:0]  div_max_nx = (ctrl_b_reg[7:5] == `SDAC_DIV12_CODE) ?
                           5'(`SDAC_DIV12_CYCLES / 2 - 1) : 5'(`SDAC_DIV30_CYCLES / 2 - 1); // RULE_13
  wire [16:0] osr_full   = 17'(`SDAC_OSR_BASE) >> ctrl_a_reg[`SDAC_LSB_OSR +: 4];  // RULE_12

  always_ff @(posedge CLK) begin
    if (SRST || filt_rst) begin
      div_cnt_reg <= 5'h00;
      div_max_reg <= 5'h00;
      MOD_CLK     <= 1'b0;
      osr_reg     <= 16'h0000;
    end else begin
      div_max_reg <= div_max_nx;
      osr_reg     <= osr_full[15:0];                                               // RULE_12
      if (!mod_en) begin
        div_cnt_reg <= 5'h00;
        MOD_CLK     <= 1'b0;                                                       // RULE_18
      end else if (div_cnt_reg >= div_max_reg) begin
        div_cnt_reg <= 5'h00;
        MOD_CLK     <= mod_en && !MOD_CLK;
      end else begin
        div_cnt_reg <= div_cnt_reg + 5'h01;
      end
    end
  end

  // =====================================================
  // Analog control outputs
  sdac_analog_t analog_next;
  always_comb begin
    analog_next.ref_voltage_select   = sdac_ref_t'(gain_ref_reg[`SDAC_LSB_REF +: 2]); // RULE_01
    analog_next.converter_gain_value = gain_ref_reg[`SDAC_BIT_CONV_GAIN];          // RULE_02
    analog_next.amp_gain_value       = amp_gain_decode(gain_ref_reg[2:0]);         // RULE_03
    analog_next.input_link_ctrl      = conn_reg[`SDAC_BIT_LINK];                   // RULE_04
    analog_next.input_route_ctrl     = conn_reg[`SDAC_LSB_ROUTE +: 2];
    analog_next.amp_bypass_ctrl      = conn_reg[`SDAC_BIT_BYPASS];                 // RULE_05
    analog_next.amp_enable           = conn_reg[`SDAC_BIT_AMP_EN];                 // RULE_06
    analog_next.neg_input_select     = chan_reg[7:4];                              // RULE_07
    analog_next.pos_input_select     = chan_reg[3:0];                              // RULE_08
    analog_next.modulator_enable     = mod_en;                                     // RULE_18
    analog_next.decimator_reset      = filt_rst || !dec_en;                        // RULE_10 RULE_11
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ANALOG_CTRL <= '0;
      ADC_IRQ_REQ <= 1'b0;
      OSR_VALUE   <= 16'h0000;
    end else begin
      ANALOG_CTRL <= analog_next;
      ADC_IRQ_REQ <= eoc_set;                                                      // RULE_15 RULE_21
      OSR_VALUE   <= osr_reg;
    end
  end

  // =====================================================
  // AXI read path
  logic ar_ok_reg;
  wire  ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
  wire [7:0] rd_byte = rd_mux(S_AXI_ARADDR, gain_ref_reg, conn_reg, chan_reg, result_reg,
                              ctrl_a_reg, ctrl_b_reg, ctrl_c_reg);                 // RULE_09

  always_ff @(posedge CLK) begin
    if (SRST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= 2'h0;
      ar_ok_reg     <= 1'b0;
    end else begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !ar_take;
      ar_ok_reg     <= 1'b0;
      if (ar_take) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= {24'h000000, rd_byte};                                     // RULE_20
        S_AXI_RRESP  <= addr_ok(S_AXI_ARADDR) ? 2'h0 : 2'h2;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ===== design/sdac_defines.svh
`ifndef SDAC_DEFINES_SVH
`define SDAC_DEFINES_SVH

// =====================================================
// Register byte addresses
`define SDAC_ADDR_PGA_GAIN_REF  8'h00
`define SDAC_ADDR_PGA_CONN      8'h04
`define SDAC_ADDR_CHAN_SEL      8'h08
`define SDAC_ADDR_RES_LOW       8'h0C
`define SDAC_ADDR_RES_MID       8'h10
`define SDAC_ADDR_RES_HIGH      8'h14
`define SDAC_ADDR_CTRL_A        8'h18
`define SDAC_ADDR_CTRL_B        8'h1C
`define SDAC_ADDR_CTRL_C        8'h20

// =====================================================
// Implemented bit masks
`define SDAC_MASK_PGA_GAIN_REF  8'h6F
`define SDAC_MASK_PGA_CONN      8'h73
`define SDAC_MASK_CHAN_SEL      8'hFF
`define SDAC_MASK_CTRL_A        8'hBE
`define SDAC_MASK_CTRL_B        8'hE6
`define SDAC_MASK_CTRL_C        8'hDF
`define SDAC_MASK_CTRL_C_WR     8'h10

// =====================================================
// Reset values
`define SDAC_RST_ZERO           8'h00
`define SDAC_RST_CTRL_C         8'h02
`define SDAC_RST_CHAN_SEL       8'h00

// =====================================================
// Field positions
`define SDAC_BIT_FILT_RST       7
`define SDAC_BIT_DEC_EN         5
`define SDAC_LSB_OSR            1
`define SDAC_LSB_CLKDIV         5
`define SDAC_BIT_LATCH          2
`define SDAC_BIT_EOC            1
`define SDAC_BIT_MOD_EN         4
`define SDAC_LSB_REF            5
`define SDAC_BIT_CONV_GAIN      3
`define SDAC_BIT_LINK           6
`define SDAC_LSB_ROUTE          4
`define SDAC_BIT_BYPASS         1
`define SDAC_BIT_AMP_EN         0

// =====================================================
// Legal codes and timing counts
`define SDAC_OSR_MAX_CODE       4'h8
`define SDAC_DIV30_CODE         3'h0
`define SDAC_DIV12_CODE         3'h2
`define SDAC_DIV30_CYCLES       30
`define SDAC_DIV12_CYCLES       12
`define SDAC_OSR_BASE           32768
`define SDAC_NEG_MIN            4'h8
`define SDAC_NEG_MAX            4'hE
`define SDAC_POS_MIN            4'h8
`define SDAC_POS_MAX            4'hD

`endif

// ===== design/sdac_pkg.sv
package sdac_pkg;

  typedef enum logic [1:0] {
    SDAC_REF_DAC,
    SDAC_REF_REG,
    SDAC_REF_HALF,
    SDAC_REF_QUARTER
  } sdac_ref_t;

  typedef struct packed {
    sdac_ref_t  ref_voltage_select;
    logic       converter_gain_value;
    logic [7:0] amp_gain_value;
    logic       input_link_ctrl;
    logic [1:0] input_route_ctrl;
    logic       amp_bypass_ctrl;
    logic       amp_enable;
    logic [3:0] neg_input_select;
    logic [3:0] pos_input_select;
    logic       modulator_enable;
    logic       decimator_reset;
  } sdac_analog_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] data;
  } sdac_result_t;

endpackage

// ===== sim/sdac_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checks
module sdac_chk
  import sdac_pkg::*;
(
  input wire logic         CLK,
  input wire logic         SRST,
  input wire logic         S_AXI_AWREADY,
  input wire logic         S_AXI_WREADY,
  input wire logic [1:0]   S_AXI_BRESP,
  input wire logic         S_AXI_BVALID,
  input wire logic         S_AXI_BREADY,
  input wire logic         S_AXI_ARREADY,
  input wire logic [31:0]  S_AXI_RDATA,
  input wire logic         S_AXI_RVALID,
  input wire logic         S_AXI_RREADY,
  input wire logic         FILTER_DONE,
  input wire sdac_analog_t ANALOG_CTRL,
  input wire logic         MOD_CLK,
  input wire logic [15:0]  OSR_VALUE,
  input wire logic         ADC_IRQ_REQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  sequence mod_off2;
    !ANALOG_CTRL.modulator_enable [*2];
  endsequence
  bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
  rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
  rdata_upper_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  wr_busy_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken during response");
  rd_busy_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken during response");
  irq_pulse_a: assert property (ADC_IRQ_REQ |=> !ADC_IRQ_REQ)
    else $error("request longer than one cycle");
  irq_cause_a: assert property (ADC_IRQ_REQ |->
    $past(FILTER_DONE, 3) && !$past(FILTER_DONE, 4))
    else $error("request without conversion end");
  modclk_off_a: assert property (mod_off2 |-> !MOD_CLK)
    else $error("converter clock runs while disabled");
  amp_onehot_a: assert property (|ANALOG_CTRL.amp_gain_value |->
    $onehot(ANALOG_CTRL.amp_gain_value)) else $error("amp gain not power of two");
  osr_legal_a: assert property (OSR_VALUE != 16'h0 |->
    $onehot(OSR_VALUE) && OSR_VALUE >= 16'h0080)
    else $error("illegal oversampling ratio");
endmodule
bind sdac_ctrl sdac_chk sdac_chk_inst (.CLK(CLK), .SRST(SRST),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .FILTER_DONE(FILTER_DONE), .ANALOG_CTRL(ANALOG_CTRL),
  .MOD_CLK(MOD_CLK), .OSR_VALUE(OSR_VALUE), .ADC_IRQ_REQ(ADC_IRQ_REQ));
`default_nettype wire

// ===== sim/sdac_filt_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Filter and modulator model
module sdac_filt_model (
  input  wire logic        clk,
  input  wire logic        mod_clk,
  input  wire logic        go,
  input  wire logic [3:0]  dly,
  input  wire logic [23:0] word,
  output logic             done,
  output logic [23:0]      data,
  output logic             mod_bit
);
  initial begin
    done = 1'h0;
    data = 24'h0;
    mod_bit = 1'h0;
    forever begin
      @(posedge clk);
      if (go) begin
        repeat (dly) @(posedge clk);
        data <= word;
        done <= 1'h1;
        repeat (6) @(posedge clk);
        done <= 1'h0;
        data <= ~word;
      end
    end
  end
  always @(posedge mod_clk) mod_bit <= ~mod_bit;
endmodule
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 1'h0, srst = 1'h1, go = 1'h0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, mclk, irq, fdone, mbit;
  logic [1:0]  bresp, rresp;
  logic [23:0] fdata, word = 24'h0;
  logic [15:0] oversample_ratio;
  logic [1:0]  rsp;
  logic [3:0]  dly = 4'h1;
  sdac_pkg::sdac_analog_t actl;
  int          n_mismatch = 0, total_checks = 0, n_irq = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) if (irq === 1'h1) n_irq <= n_irq + 1;
  sdac_ctrl sdac_ctrl_inst (.CLK(clk), .SRST(srst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .MOD_BIT(mbit),
    .FILTER_DATA(fdata), .FILTER_DONE(fdone), .ANALOG_CTRL(actl), .MOD_CLK(mclk),
    .OSR_VALUE(oversample_ratio), .ADC_IRQ_REQ(irq));
  sdac_filt_model sdac_filt_model_inst (.clk(clk), .mod_clk(mclk), .go(go), .dly(dly),
    .word(word), .done(fdone), .data(fdata), .mod_bit(mbit));
  // ==========
  // Bus, check and conversion tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end while (!tb);
    bready <= 1'h0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    logic ta, tr;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge clk);
      ta = arvalid & arready;
      tr = rvalid;
      v = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'h0;
    end while (!tr);
    rready <= 1'h0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] v;
    logic [1:0]  r;
    rd(a, v, r);
    chk("register read", {24'h0, e}, v);
  endtask
  task automatic conv(input logic [23:0] w, input logic [3:0] dl, input int e);
    int k;
    k = n_irq;
    @(posedge clk);
    word <= w;
    dly <= dl;
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    for (int i = 0; i < 40 && n_irq == k; i++) @(posedge clk);
    repeat (8) @(posedge clk);
    chk("request count", 32'(e), 32'(n_irq - k));
  endtask
  // ==========
  // Scenarios
  task automatic t_regs;
    logic [1:0]  r;
    logic [31:0] v;
    logic [7:0]  ta [10] = '{8'h00, 8'h04, 8'h08, 8'h08, 8'h18, 8'h18, 8'h1C, 8'h1C, 8'h20, 8'h0C};
    logic [7:0]  td [10] = '{8'hFF, 8'hFF, 8'hED, 8'hFF, 8'h30, 8'h32, 8'h40, 8'h20, 8'hFF, 8'hFF};
    logic [7:0]  te [10] = '{8'h6F, 8'h73, 8'hED, 8'hED, 8'h30, 8'h30, 8'h40, 8'h40, 8'h12, 8'h00};
    for (int i = 0; i < 9; i++) rdc(8'(i * 4), (i == 8) ? 8'h02 : 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, 8'(i), r);
      chk("amp gain", 32'(1 << i), 32'(actl.amp_gain_value));
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 8'((i << 5) | 8), r);
      chk("reference", 32'(i), 32'(actl.ref_voltage_select));
      chk("conv gain", 32'h1, 32'(actl.converter_gain_value));
    end
    for (int i = 0; i < 10; i++) begin
      wr(ta[i], td[i], r);
      rdc(ta[i], te[i]);
    end
    chk("link route", 32'h1F, 32'({actl.input_link_ctrl, actl.input_route_ctrl,
      actl.amp_bypass_ctrl, actl.amp_enable}));
    chk("inputs", 32'hED, 32'({actl.neg_input_select, actl.pos_input_select}));
    chk("oversampling", 32'h80, 32'(oversample_ratio));
    chk("decimator", 32'h0, 32'(actl.decimator_reset));
    wr(8'h24, 8'h55, r);
    chk("unmapped write", 32'h2, 32'(r));
    rd(8'h24, v, r);
    chk("unmapped read", 32'h2, {v[29:0], r});
    $display("test registers done");
  endtask
  task automatic t_clk;
    logic [1:0] r;
    realtime    t0;
    for (int i = 0; i < 2; i++) begin
      wr(8'h1C, i ? 8'h40 : 8'h00, r);
      repeat (2) @(posedge mclk);
      t0 = $realtime;
      @(posedge mclk);
      chk("clock divide", i ? 32'hC : 32'h1E, 32'($rtoi(($realtime - t0) / 5.0)));
    end
    $display("test clock done");
  endtask
  task automatic t_conv;
    logic [1:0] r;
    wr(8'h18, 8'hB0, r);
    wr(8'h18, 8'h30, r);
    conv(24'hA5C3E1, 4'h1, 1);
    rdc(8'h0C, 8'hE1);
    rdc(8'h10, 8'hC3);
    rdc(8'h14, 8'hA5);
    rdc(8'h1C, 8'h42);
    wr(8'h1C, 8'h44, r);
    rdc(8'h1C, 8'h44);
    conv(24'h0F1E2D, 4'h9, 0);
    rdc(8'h1C, 8'h44);
    rdc(8'h0C, 8'hE1);
    wr(8'h1C, 8'h40, r);
    conv(24'h0F1E2D, 4'h9, 1);
    rdc(8'h0C, 8'h2D);
    rdc(8'h14, 8'h0F);
    $display("test conversion done");
  endtask
  task automatic t_freset;
    logic [1:0] r;
    wr(8'h18, 8'hB0, r);
    chk("decimator reset", 32'h1, 32'(actl.decimator_reset));
    conv(24'h777777, 4'h1, 0);
    chk("converter clock", 32'h0, 32'(mclk));
    rdc(8'h0C, 8'h2D);
    wr(8'h18, 8'h30, r);
    $display("test filter reset done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'h0;
    t_regs();
    wr(8'h20, 8'h10, rsp);
    chk("ctrl c response", 32'h0, 32'(rsp));
    t_clk();
    t_conv();
    t_freset();
    give_verdict();
  end
  initial begin
    #100000;
    n_mismatch++;
    give_verdict();
  end
endmodule
`default_nettype wire
